/* File: hdl/amp_upper_control_word_decode.sv */
// control word receiver, read-back and field decode for the stereo amplifier
`timescale 1ns/1ps
`default_nettype none
module amp_upper_control_word_decode (
  // clock, reset, enable
  input  wire logic                      i_clk,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_ce,
  // three wire serial control port
  input  wire logic                      i_spi_en_n,
  input  wire logic                      i_spi_clk,
  input  wire logic                      i_spi_data_in,
  output logic                           o_spi_data_out,
  output logic                           o_spi_data_oe_n,
  // audio timing and clip status
  input  wire logic                      i_word_clk,
  input  wire logic                      i_single_speed,
  input  wire logic                      i_vol_clip,
  input  wire logic                      i_bass_clip,
  // volume
  output logic [8:0]                     o_left_volume,
  output logic [8:0]                     o_right_volume,
  output logic                           o_left_soft_mute,
  output logic                           o_right_soft_mute,
  // tone
  output logic                           o_bass_boost_sel,
  output logic [3:0]                     o_bass_level,
  output amp_ctrl_pkg::bass_corner_t     o_bass_corner,
  output logic                           o_treble_boost_sel,
  output logic [3:0]                     o_treble_level,
  output amp_ctrl_pkg::trb_corner_t      o_treble_corner,
  // filter, limiter, dither
  output amp_ctrl_pkg::deemph_t          o_emphasis_filter_select,
  output logic                           o_limiter_enable,
  output logic                           o_reduce_volume,
  output logic                           o_remove_bass,
  output logic                           o_gain_down_step,
  output logic                           o_gain_up_step,
  output logic                           o_dither_enable,
  // format, mix, output stage
  output amp_ctrl_pkg::fmt_t             o_input_format,
  output logic [3:0]                     o_mix_mute_select,
  output amp_ctrl_pkg::src_t             o_left_src,
  output amp_ctrl_pkg::src_t             o_right_src,
  output logic                           o_bridge_enable,
  output logic [4:0]                     o_p_comp,
  output logic [4:0]                     o_n_comp,
  output logic                           o_auto_low_power,
  output amp_ctrl_pkg::pwm_mode_t        o_pwm_mode
);
  import amp_ctrl_pkg::*;

  // ---------------------------------------------------------------------------
  // types and state
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_HEAD  = 4'h2,
    ST_WRITE = 4'h4,
    ST_READ  = 4'h8
  } port_state_t;

  port_state_t state;
  port_state_t next_state;
  logic [6:0]  bit_cnt;
  logic [7:0]  head;
  logic [63:0] wr_shift;
  logic [63:0] rd_shift;
  logic [63:0] ctrl;
  logic [3:0]  pin_lvl;
  logic [3:0]  pin_rise;
  logic [3:0]  pin_fall;

  function automatic logic is_soft_mute(input logic [8:0] code);
    is_soft_mute = (code == VOL_SOFT_MUTE);
  endfunction

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  // the serial port and word clock run free of i_clk, so every pin is cleaned first;
  // the enable goes in inverted so its idle level matches the synchroniser reset and no false frame follows reset
  pin_sync #(
    .W (4)
  ) u_pin_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_pins    ({i_word_clk, i_spi_data_in, i_spi_clk, ~i_spi_en_n}),
    .o_level   (pin_lvl),
    .o_rise    (pin_rise),
    .o_fall    (pin_fall)
  );

  // serial clock edges only count inside a frame; limits the port to about clk/8
  wire        en_active   = pin_lvl[0];
  wire        frame_start = pin_rise[0];
  wire        ck_rise     = pin_rise[1] && en_active;
  wire        ck_fall     = pin_fall[1] && en_active;
  wire        din         = pin_lvl[2];
  wire        wclk_tick   = pin_rise[3];

  // ---------------------------------------------------------------------------
  // frame decode
  // ---------------------------------------------------------------------------
  wire [7:0]  head_next  = {head[6:0], din};
  wire        head_done  = (state == ST_HEAD) && ck_rise && (bit_cnt == PRE_LAST);
  wire        id_ok      = (head_next[ID_MSB:ID_LSB] == PRE_ID);
  wire        head_rw    = head_next[0];
  wire        frame_done = ck_rise && (bit_cnt == FRAME_LAST);
  wire        commit     = (state == ST_WRITE) && frame_done;
  wire [63:0] wr_full    = {wr_shift[62:0], din};

  // next state; a header with the wrong pattern is ignored until the next frame
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (frame_start)
          next_state = ST_HEAD;
      ST_HEAD:
        if (!en_active)
          next_state = ST_IDLE;
        else if (head_done)
          next_state = !id_ok ? ST_IDLE : (head_rw ? ST_READ : ST_WRITE);
      ST_WRITE, ST_READ:
        if (!en_active || frame_done)
          next_state = ST_IDLE;   // see (R26)
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      state <= ST_IDLE;
    else if (i_ce)
      state <= next_state;
  end

  // bit counter covers the whole 72 bit frame and clears on its last bit, never passing it
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      bit_cnt <= 7'h00;
    else if (i_ce && (state == ST_IDLE || frame_done))
      bit_cnt <= 7'h00;
    else if (i_ce && ck_rise)
      bit_cnt <= bit_cnt + 7'h01;   // see (R26)
  end

  // ---------------------------------------------------------------------------
  // shift registers and the live control word
  // ---------------------------------------------------------------------------
  // incoming bits sit in a shadow so a short frame never disturbs the live word
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      head     <= 8'h00;
      wr_shift <= 64'h0;
    end
    else if (i_ce && ck_rise)
    begin
      if (state == ST_HEAD)
        head <= head_next;
      if (state == ST_WRITE)
        wr_shift <= wr_full;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      ctrl <= CTRL_RST;   // see (R7) (R8) (R10) (R12) (R13) (R14)
    else if (i_ce && commit)
      ctrl <= wr_full;    // see (R27)
  end

  // read-back: msb first, first bit driven at the falling edge after the header
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      rd_shift        <= 64'h0;
      o_spi_data_out  <= 1'b0;
      o_spi_data_oe_n <= 1'b1;
    end
    else if (i_ce)
    begin
      if (head_done && head_rw)
        rd_shift <= ctrl;
      else if (state == ST_READ && ck_fall)
        rd_shift <= {rd_shift[62:0], 1'b0};
      if (state == ST_READ && ck_fall)
      begin
        o_spi_data_out  <= rd_shift[63];
        o_spi_data_oe_n <= 1'b0;
      end
      else if (state != ST_READ)
        o_spi_data_oe_n <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------------------
  // volume and tone fields go straight from the live word
  assign o_left_volume      = ctrl[VOL_L_LSB +: VOL_W];                 // see (R19)
  assign o_right_volume     = ctrl[VOL_R_LSB +: VOL_W];                 // see (R19)
  assign o_left_soft_mute   = is_soft_mute(o_left_volume);              // see (R18)
  assign o_right_soft_mute  = is_soft_mute(o_right_volume);             // see (R18)
  assign o_bass_boost_sel   = ctrl[BASS_BOOST];                         // see (R21)
  assign o_bass_level       = ctrl[BASS_LVL_LSB +: 4];                  // see (R21)
  assign o_bass_corner      = bass_corner_t'(ctrl[BASS_COR_LSB +: 2]);  // see (R22)
  assign o_treble_boost_sel = ctrl[TRB_BOOST];                          // see (R23)
  assign o_treble_level     = ctrl[TRB_LVL_LSB +: 4];                   // see (R23)
  assign o_treble_corner    = trb_corner_t'(ctrl[TRB_COR_LSB +: 2]);    // see (R24) (R25)

  // limiter, dither, format, mix and output stage controls
  assign o_limiter_enable   = ctrl[LIM_EN];                             // see (R3)
  assign o_dither_enable    = ctrl[DITHER_EN];                          // see (R5)
  assign o_input_format     = fmt_t'(ctrl[FMT_LSB +: 2]);               // see (R9)
  assign o_mix_mute_select  = ctrl[MIX_LSB +: 4];                       // see (R10)
  assign o_left_src         = src_t'(ctrl[MIX_LSB + 2 +: 2]);           // see (R11)
  assign o_right_src        = src_t'(ctrl[MIX_LSB +: 2]);               // see (R11)
  assign o_bridge_enable    = ctrl[BRIDGE_EN];                          // see (R12)
  assign o_n_comp           = ctrl[NCOMP_LSB +: 5];                     // see (R14)
  assign o_auto_low_power   = ctrl[AUTO_LP];                            // see (R15)
  assign o_pwm_mode         = pwm_mode_t'({ctrl[HI_SPEED], ctrl[H_METHOD]}); // see (R16) (R17)

  wire [4:0] p_raw      = ctrl[PCOMP_LSB +: 5];
  wire       lim_mode   = ctrl[LIM_MODE];
  wire       clipping   = i_vol_clip || i_bass_clip;
  wire [4:0] attack_exp = {1'b0, ctrl[ATTACK_LSB +: 3], 1'b0};
  wire [4:0] rel_exp    = {1'b0, ctrl[RELEASE_LSB +: 4]} + RELEASE_BASE;

  // de-emphasis drops out above single speed; p trim clamps so a bad write stays safe
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_emphasis_filter_select <= DE_NONE;
      o_reduce_volume          <= 1'b0;
      o_remove_bass            <= 1'b0;
      o_p_comp                 <= PCOMP_RST;
    end
    else if (i_ce)
    begin
      o_emphasis_filter_select <= i_single_speed ? deemph_t'(ctrl[DEEMPH_LSB +: 2]) : DE_NONE; // see (R1) (R2)
      o_reduce_volume          <= ctrl[LIM_EN] && (i_vol_clip || (i_bass_clip && lim_mode)); // see (R4)
      o_remove_bass            <= ctrl[LIM_EN] && i_bass_clip && !lim_mode;                 // see (R4)
      o_p_comp                 <= (p_raw > COMP_MAX) ? COMP_MAX : p_raw;                    // see (R13)
    end
  end

  // ---------------------------------------------------------------------------
  // limiter pacing
  // ---------------------------------------------------------------------------
  // attack steps 4^code word periods per 0.5dB, release 2^(code+4)
  gain_step_pacer #(
    .CNT_W (20)
  ) u_attack (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_run     (ctrl[LIM_EN] && clipping),
    .i_tick    (wclk_tick),
    .i_exp     (attack_exp),   // see (R7)
    .o_step    (o_gain_down_step)
  );

  gain_step_pacer #(
    .CNT_W (20)
  ) u_release (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ce      (i_ce),
    .i_run     (ctrl[LIM_EN] && !clipping),
    .i_tick    (wclk_tick),
    .i_exp     (rel_exp),      // see (R8)
    .o_step    (o_gain_up_step)
  );

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_last_write_bit;
    i_ce && state == ST_WRITE && ck_rise && bit_cnt == FRAME_LAST;
  endsequence

  sequence s_read_edge;
    i_ce && state == ST_READ && ck_fall;
  endsequence

  a_word_commit_whole: assert property ($changed(ctrl) |-> $past(commit && i_ce)) // see (R27)
    else $error("control word changed without a full frame");

  a_commit_loads_word: assert property (s_last_write_bit |=> ctrl == $past(wr_full)) // see (R26)
    else $error("completed frame not loaded");

  a_frame_len_bound: assert property (bit_cnt <= FRAME_LAST) // see (R26)
    else $error("bit count ran past the frame");

  a_deemph_blocked: assert property ((i_ce && !i_single_speed) |=> o_emphasis_filter_select == DE_NONE) // see (R2)
    else $error("de-emphasis active outside single speed");

  a_deemph_follows: assert property ((i_ce && i_single_speed)
                                     |=> o_emphasis_filter_select == $past(ctrl[DEEMPH_LSB +: 2])) // see (R1)
    else $error("de-emphasis code not passed through");

  a_vol_clip_reduce: assert property ((i_ce && ctrl[LIM_EN] && i_vol_clip) |=> o_reduce_volume) // see (R4)
    else $error("volume clip did not reduce volume");

  a_bass_clip_mode: assert property ((i_ce && ctrl[LIM_EN] && i_bass_clip && !lim_mode)
                                     |=> o_remove_bass && !($past(i_vol_clip) ^ o_reduce_volume)) // see (R4)
    else $error("bass clip response wrong");

  a_limiter_off_quiet: assert property ((i_ce && !ctrl[LIM_EN]) |=> !o_reduce_volume && !o_remove_bass) // see (R3)
    else $error("limiter acted while disabled");

  a_p_comp_limit: assert property (o_p_comp <= COMP_MAX) // see (R13)
    else $error("p compensation above limit");

  a_read_drives: assert property (s_read_edge |=> !o_spi_data_oe_n && o_spi_data_out == $past(rd_shift[63])) // see (R26)
    else $error("read bit not driven");

  a_soft_mute_code: assert property (o_left_soft_mute == (o_left_volume == VOL_SOFT_MUTE)) // see (R18)
    else $error("soft mute flag wrong");

  a_bridge_reset: assert property (disable iff (1'b0) i_sys_rst |=> !o_bridge_enable) // see (R12)
    else $error("bridge enabled after reset");
endmodule // amp_upper_control_word_decode
`default_nettype wire

/* File: hdl/amp_ctrl_pkg.sv */
// package: field map, reset values and encodings of the amplifier control word
// ----------------------------------------------------------------------------
// Overview of operation
// (R1) de-emphasis code 00 none, 01 44.1kHz, 10 32kHz, 11 48kHz at bits 32-33.
// (R2) de-emphasis acts only in single speed mode, never in dual or quad.
// (R3) bit 34 set enables the clip limiter, clear disables it.
// (R4) bit 35 clear removes bass when bass clips, set reduces volume; volume clip reduces volume.
// (R5) bit 36 turns the small dc dither offset away from converter zero.
// (R6) host turns dither for H-type pwm; usually leaves it off for R-type.
// (R7) attack code gives 4^code word clock periods per 0.5dB step, default 001.
// (R8) release code at bits 40-43 paces gain recovery, default 1010.
// (R9) bits 44-45 pick i2s 24, left justified, right justified 16 or 24 bit.
// (R10) mix field bits 46-49 gives mute, mono and swap, default 1001.
// (R11) upper mix pair drives left, lower pair right: mute, right, left, average.
// (R12) bit 50 enables the output bridge in direct drive, resets to 0.
// (R13) p-side compensation bits 51-55 default 10000; host keeps it at most 10000.
// (R14) n-side compensation bits 56-60 default 00000, trims n transistor error.
// (R15) bit 61 enables auto low power, which allows digital silence.
// (R16) bit 62 picks low or high speed, bit 63 picks R-type or H-type pwm.
// (R17) speed and method: R 500kHz, H 1MHz, R 1MHz, H 2MHz.
// (R18) volume steps 0.5dB, -94.5dB to +25dB; last code is soft mute -95dB.
// (R19) left volume bits 0-8, right volume bits 9-17, same code table.
// (R20) host steps volume through every 0.5dB level, never jumps.
// (R21) bass level bits 19-22 give 0-15dB in 1dB; bit 18 boost or cut.
// (R22) bass corner bits 23-24: 00 50Hz, 01 100Hz, 10 200Hz.
// (R23) treble level bits 26-29 give 0-15dB in 1dB; bit 25 boost or cut.
// (R24) treble corner bits 30-31 take 4kHz, 8kHz or 12kHz.
// (R25) treble corner codes: 00 4kHz, 01 8kHz, 10 12kHz.
// (R26) each update is one 72 bit serial word with 72 serial clocks.
// (R27) settings change only after a whole control word has arrived.
// ----------------------------------------------------------------------------
`default_nettype none
package amp_ctrl_pkg;
  // ---------------------------------------------------------------------------
  // serial frame
  // ---------------------------------------------------------------------------
  localparam int         WORD_W     = 64;
  localparam logic [6:0] PRE_LAST   = 7'h07;  // count of the last header bit
  localparam logic [6:0] FRAME_LAST = 7'h47;  // count of bit 72 of the frame
  localparam logic [4:0] PRE_ID     = 5'h11;  // fixed header pattern after the two address bits
  localparam int         ID_LSB     = 1;
  localparam int         ID_MSB     = 5;
  // ---------------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------------
  localparam int VOL_W        = 9;
  localparam int VOL_L_LSB    = 0;
  localparam int VOL_R_LSB    = 9;
  localparam int BASS_BOOST   = 18;
  localparam int BASS_LVL_LSB = 19;
  localparam int BASS_COR_LSB = 23;
  localparam int TRB_BOOST    = 25;
  localparam int TRB_LVL_LSB  = 26;
  localparam int TRB_COR_LSB  = 30;
  localparam int DEEMPH_LSB   = 32;
  localparam int LIM_EN       = 34;
  localparam int LIM_MODE     = 35;
  localparam int DITHER_EN    = 36;
  localparam int ATTACK_LSB   = 37;
  localparam int RELEASE_LSB  = 40;
  localparam int FMT_LSB      = 44;
  localparam int MIX_LSB      = 46;
  localparam int BRIDGE_EN    = 50;
  localparam int PCOMP_LSB    = 51;
  localparam int NCOMP_LSB    = 56;
  localparam int AUTO_LP      = 61;
  localparam int HI_SPEED     = 62;
  localparam int H_METHOD     = 63;
  // ---------------------------------------------------------------------------
  // reset values and limits
  // ---------------------------------------------------------------------------
  localparam logic [8:0] VOL_RST       = 9'h0fa;  // -2dB
  localparam logic [8:0] VOL_SOFT_MUTE = 9'h040;  // -95dB
  localparam logic [2:0] ATTACK_RST    = 3'h1;
  localparam logic [3:0] RELEASE_RST   = 4'ha;
  localparam logic [3:0] MIX_RST       = 4'h9;
  localparam logic [4:0] PCOMP_RST     = 5'h10;
  localparam logic [4:0] COMP_MAX      = 5'h10;
  localparam logic [4:0] RELEASE_BASE  = 5'h04;   // release code 0 is 2^4 periods
  localparam logic [63:0] CTRL_RST = {3'h0, 5'h00, PCOMP_RST, 1'b0, MIX_RST, 2'h0, RELEASE_RST,
                                      ATTACK_RST, 3'h0, 2'h0, 2'h0, 4'h0, 1'b0, 2'h0, 4'h0, 1'b0,
                                      VOL_RST, VOL_RST};
  // ---------------------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {DE_NONE = 2'h0, DE_44K1 = 2'h1, DE_32K = 2'h2, DE_48K = 2'h3} deemph_t;
  typedef enum logic [1:0] {SRC_MUTE = 2'h0, SRC_RIGHT = 2'h1, SRC_LEFT = 2'h2, SRC_AVG = 2'h3} src_t;
  typedef enum logic [1:0] {FMT_I2S24 = 2'h0, FMT_LJ = 2'h1, FMT_RJ16 = 2'h2, FMT_RJ24 = 2'h3} fmt_t;
  typedef enum logic [1:0] {PWM_R_500K = 2'h0, PWM_H_1M = 2'h1, PWM_R_1M = 2'h2, PWM_H_2M = 2'h3} pwm_mode_t;
  typedef enum logic [1:0] {TRB_4K = 2'h0, TRB_8K = 2'h1, TRB_12K = 2'h2, TRB_RSVD = 2'h3} trb_corner_t;
  typedef enum logic [1:0] {BASS_50 = 2'h0, BASS_100 = 2'h1, BASS_200 = 2'h2, BASS_RSVD = 2'h3} bass_corner_t;
endpackage
`default_nettype wire

/* File: hdl/pin_sync.sv */
// two-flop synchroniser with edge detection for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_ce,
  // raw pins and cleaned views
  input  wire logic [W-1:0] i_pins,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_rise,
  output logic      [W-1:0] o_fall
);
  logic [W-1:0] meta;
  logic [W-1:0] prev;

  // the first stage feeds only the second; edges compare stage two with stage three
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      meta    <= '0;
      o_level <= '0;
      prev    <= '0;
    end
    else if (i_ce)
    begin
      meta    <= i_pins;
      o_level <= meta;
      prev    <= o_level;
    end
  end

  assign o_rise = o_level & ~prev;
  assign o_fall = ~o_level & prev;
endmodule // pin_sync
`default_nettype wire

/* File: hdl/gain_step_pacer.sv */
// counts word clock periods and marks each limiter gain step of 0.5dB
`timescale 1ns/1ps
`default_nettype none
module gain_step_pacer #(
  parameter int CNT_W = 20
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_ce,
  // pacing
  input  wire logic       i_run,
  input  wire logic       i_tick,
  input  wire logic [4:0] i_exp,
  output logic            o_step
);
  logic [CNT_W-1:0] cnt;
  wire  [CNT_W-1:0] last = (CNT_W'(1) << i_exp) - CNT_W'(1);

  // a stalled run restarts the count so a new clip starts a fresh period
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      cnt    <= '0;
      o_step <= 1'b0;
    end
    else if (i_ce)
    begin
      o_step <= i_run && i_tick && (cnt >= last);
      if (!i_run)
        cnt <= '0;
      else if (i_tick)
        cnt <= (cnt >= last) ? '0 : cnt + CNT_W'(1);
    end
  end
endmodule // gain_step_pacer
`default_nettype wire

/* File: tb/host_model.sv */
// host controller model: sends and reads back serial control frames
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // serial port pins
  output logic      o_en_n,
  output logic      o_sck,
  output logic      o_sdo,
  input  wire logic i_wire
);
  // idle: frame off, serial clock standing low
  initial
  begin
    o_en_n = 1'b1;
    o_sck = 1'b0;
    o_sdo = 1'b0;
  end
  // one frame of n bits, header first; read data taken at each rise
  task automatic xfer(input logic rw, input logic [63:0] d, input int n, output logic [63:0] q);
    logic [71:0] f;
    f = {7'b0010001, rw, d};
    q = '0;
    o_en_n = 1'b0;
    #100;
    for (int i = 71; i > 71 - n; i--)
    begin
      o_sdo = f[i];
      #80 o_sck = 1'b1;
      q = {q[62:0], i_wire};
      #80 o_sck = 1'b0;
    end
    // a released line must not keep showing the last bit
    o_sdo = ~o_sdo;
    #100 o_en_n = 1'b1;
    #200;  // enable stays high well over three clocks between frames
  endtask
endmodule  // host_model
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the amplifier control word decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import amp_ctrl_pkg::*;
  logic i_clk, i_sys_rst, i_ce, i_word_clk, i_single_speed, i_vol_clip, i_bass_clip;
  wire logic i_spi_en_n, i_spi_clk, h_sdo, i_spi_data_in;
  logic o_spi_data_out, o_spi_data_oe_n, o_left_soft_mute, o_right_soft_mute, o_bass_boost_sel;
  logic o_treble_boost_sel, o_limiter_enable, o_reduce_volume, o_remove_bass, o_gain_down_step;
  logic o_gain_up_step, o_dither_enable, o_bridge_enable, o_auto_low_power;
  logic [8:0] o_left_volume, o_right_volume;
  logic [3:0] o_bass_level, o_treble_level, o_mix_mute_select;
  logic [4:0] o_p_comp, o_n_comp;
  bass_corner_t o_bass_corner;
  trb_corner_t o_treble_corner;
  deemph_t o_emphasis_filter_select;
  fmt_t o_input_format;
  src_t o_left_src, o_right_src;
  pwm_mode_t o_pwm_mode;
  logic [63:0] w, q;
  int errors = 0, comparisons = 0, downs = 0, ups = 0;
  // data wire: device wins while its enable is low
  assign i_spi_data_in = o_spi_data_oe_n ? h_sdo : o_spi_data_out;
  amp_upper_control_word_decode DUT (.i_clk, .i_sys_rst, .i_ce, .i_spi_en_n, .i_spi_clk, .i_spi_data_in,
    .o_spi_data_out, .o_spi_data_oe_n, .i_word_clk, .i_single_speed, .i_vol_clip, .i_bass_clip,
    .o_left_volume, .o_right_volume, .o_left_soft_mute, .o_right_soft_mute, .o_bass_boost_sel,
    .o_bass_level, .o_bass_corner, .o_treble_boost_sel, .o_treble_level, .o_treble_corner,
    .o_emphasis_filter_select, .o_limiter_enable, .o_reduce_volume, .o_remove_bass, .o_gain_down_step,
    .o_gain_up_step, .o_dither_enable, .o_input_format, .o_mix_mute_select, .o_left_src, .o_right_src,
    .o_bridge_enable, .o_p_comp, .o_n_comp, .o_auto_low_power, .o_pwm_mode);
  host_model host (.o_en_n(i_spi_en_n), .o_sck(i_spi_clk), .o_sdo(h_sdo), .i_wire(i_spi_data_in));
  // 50 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // count limiter gain strobes
  always @(posedge i_clk)
  begin
    if (o_gain_down_step === 1'b1) downs++;
    if (o_gain_up_step === 1'b1) ups++;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // word clock rises, then time for the synchroniser to catch up
  task automatic ticks(input int n);
    repeat (n)
    begin
      #200 i_word_clk = 1'b1;
      #200 i_word_clk = 1'b0;
    end
    repeat (10) @(posedge i_clk) #1;
  endtask
  task automatic t_reset;
    check({o_left_volume, o_mix_mute_select, o_left_src, o_right_src}, 17'h0fa99);
    check({o_bridge_enable, o_p_comp, o_n_comp}, 11'h200);
    host.xfer(1'b1, '0, 72, q);
    check(q, 64'h00824a200001f4fa);
  endtask
  // four writes put every code of the two-bit fields through once; right volume walks one code per write
  task automatic t_fields;
    logic [1:0] k;
    for (int n = 0; n < 4; n++)
    begin
      k = n[1:0];
      w = {k[0], k[1], k[1], 3'h0, k, 5'h10 >> k, k[1], k, ~k, k, 7'h0, k[0], 1'b0, k[0], k, k,
           2'h0, k, k[1], k, 4'hf - 4'(k), k[0], 9'h0fa - 9'(k), 9'h040};
      host.xfer(1'b0, w, 72, q);
      check({o_left_soft_mute, o_right_soft_mute, o_left_volume, o_right_volume}, {11'h440, 9'h0fa - 9'(k)});
      check({o_bass_boost_sel, o_bass_level, o_bass_corner}, {k[0], 4'hf - 4'(k), k});
      check({o_treble_boost_sel, o_treble_level, o_treble_corner}, {k[1], 2'h0, k, k});
      check({o_emphasis_filter_select, o_limiter_enable, o_dither_enable, o_input_format}, {k, k[0], k[0], k});
      check({o_left_src, o_right_src, o_mix_mute_select}, {k, ~k, k, ~k});
      check({o_bridge_enable, o_p_comp, o_n_comp, o_auto_low_power}, {k[1], 5'h10 >> k, 3'h0, k, k[1]});
      check(o_pwm_mode, k);
      @(posedge i_clk) #1 i_single_speed = 1'b0;
      repeat (3) @(posedge i_clk) #1;
      check(o_emphasis_filter_select, 2'h0);
      i_single_speed = 1'b1;
    end
    host.xfer(1'b1, '0, 72, q);
    check(q, w);
  endtask
  // a frame cut short must leave the live word alone
  task automatic t_abort;
    host.xfer(1'b0, ~w, 40, q);
    host.xfer(1'b1, '0, 72, q);
    check(q, w);
  endtask
  // volume and tone fields are kept so no level jumps
  task automatic t_limiter;
    host.xfer(1'b0, {32'h0000_0024, w[31:0]}, 72, q);
    @(posedge i_clk) #1 i_bass_clip = 1'b1;
    repeat (3) @(posedge i_clk) #1;
    check({o_reduce_volume, o_remove_bass}, 2'b01);
    i_bass_clip = 1'b0;
    i_vol_clip = 1'b1;
    downs = 0;
    ticks(40);
    check({o_reduce_volume, o_remove_bass}, 2'b10);
    check(downs, 10);
    i_vol_clip = 1'b0;
    ups = 0;
    ticks(32);
    check(ups, 2);
    // a low enable must hold the limiter outputs where they stand
    i_ce = 1'b0;
    i_vol_clip = 1'b1;
    repeat (3) @(posedge i_clk) #1;
    check(o_reduce_volume, 1'b0);
    i_ce = 1'b1;
    host.xfer(1'b0, {32'h0, w[31:0]}, 72, q);
    @(posedge i_clk) #1 i_vol_clip = 1'b1;
    repeat (3) @(posedge i_clk) #1;
    check(o_reduce_volume, 1'b0);
  endtask
  // bounded run guard, nearly three times the expected run
  initial
  begin
    #400000;
    errors++;
    wrap_up;
  end
  initial
  begin
    i_sys_rst = 1'b1;
    i_ce = 1'b1;
    i_word_clk = 1'b0;
    i_single_speed = 1'b1;
    i_vol_clip = 1'b0;
    i_bass_clip = 1'b0;
    repeat (16) @(posedge i_clk);
    #1 i_sys_rst = 1'b0;
    repeat (4) @(posedge i_clk) #1;
    t_reset;
    t_fields;
    t_abort;
    t_limiter;
    wrap_up;
  end
endmodule  // testbench
`default_nettype wire
